// ### rtl/srfd_pkg.sv
// Operation
// RQ1: On supply rising past lockout release, leave lockout and start soft-start charging.
// RQ2: After lockout release, enable driver-supply regulator once four drain pulses arrived.
// RQ3: Soft-start done and enable high starts rectification plus gate/drain open detection.
// RQ4: Enable low at soft-start completion discharges soft-start; recharge when enable rises.
// RQ5: Sample drain sense a fixed delay after gate on; below threshold marks open.
// RQ6: Gate-open fault confirmed after consecutive open pulses reach count over both drains.
// RQ7: Any sampled pulse at or above gate-open threshold clears the gate-open counter.
// RQ8: Gate-open fault asserts fail sink but keeps rectification running.
// RQ9: Count opposite drain pulses while one drain stays low; full count confirms drain-open.
// RQ10: Monitored drain at or above threshold during a counted pulse clears the counter.
// RQ11: Drain-open fault asserts fail, stops drivers, discharges soft-start and driver supply.
// RQ12: Source-open fault confirmed when source sense stays high for full mask time.
// RQ13: Source-open check ignores soft-start, no pulse count; confirmation stops everything.
// RQ14: Overvoltage held for mask time asserts fail, discharges, stops; clears on cancel/lockout.
// RQ15: In any abnormality state drive the fail output as constant current sink.
// RQ16: Latched open faults hold until lockout; then fail sink releases.
// RQ17: General comparator drives fail sink while above reference, unmasked and unlatched.
// RQ18: Sense comparator results are synchronised before feeding counters and timers.
// RQ19: Each fault keeps sticky flag; fail sink is OR of flags and comparator.
package srfd_pkg;
  localparam int CLK_MHZ = 250;
  localparam int STARTUP_PULSES = 4;
  localparam int GOP_PULSES = 2048;
  localparam int DOP_PULSES = 128;
  localparam int GOP_DELAY_NS = 2500;
  localparam int SOP_MASK_NS = 9000;
  localparam int OVP_MASK_NS = 25000;
  localparam int GOP_DELAY_CYC = (GOP_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int SOP_MASK_CYC = (SOP_MASK_NS * CLK_MHZ + 999) / 1000;
  localparam int OVP_MASK_CYC = (OVP_MASK_NS * CLK_MHZ + 999) / 1000;

  // Synchronised comparator results and registered gate drive for one channel
  typedef struct packed {
    logic drain_neg;   // drain below gate-open threshold
    logic drain_low;   // drain below open threshold
    logic src_high;    // source above open threshold
    logic gate_on;     // gate drive command of this channel
  } srfd_chan_s;

  typedef struct packed {
    logic gate_open;
    logic drain_open;
    logic src_open;
    logic overvoltage_detect;
  } srfd_fault_s;

  typedef enum logic [1:0] {
    SRFD_LOCKOUT,
    SRFD_CHARGE,
    SRFD_DISCHARGE,
    SRFD_RUN
  } srfd_state_e;
endpackage

// ### rtl/srfd_sync.sv
`timescale 1ns/1ns
module srfd_sync #(
  parameter int W = 1
) (
  input wire logic clk,            // Clock
  input wire logic nrst,           // Async reset, active low
  input wire logic [W-1:0] d,      // Asynchronous levels
  output logic [W-1:0] q           // Synchronised levels
);
  logic [W-1:0] s1_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      q <= '0;
    end else begin
      s1_q <= d;  // [RQ18]
      q <= s1_q;
    end
  end
endmodule

// ### rtl/srfd_timer.sv
`timescale 1ns/1ns
// Counts consecutive cycles of a level; done once the count is reached
module srfd_timer #(
  parameter int CYC = 16
) (
  input wire logic clk,   // Clock
  input wire logic nrst,  // Async reset, active low
  input wire logic cond,  // Level that must persist
  output logic done       // Level held for CYC cycles
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  assign cnt_d = !cond ? '0 : (cnt_q == LAST) ? cnt_q : cnt_q + 1'b1;
  assign done = cond && (cnt_q == LAST);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ### rtl/srfd_top.sv
`timescale 1ns/1ns
module srfd_top
  import srfd_pkg::*;
#(
  parameter int GOP_COUNT = srfd_pkg::GOP_PULSES,  // Gate-open confirm pulses
  parameter int DOP_COUNT = srfd_pkg::DOP_PULSES,  // Drain-open confirm pulses
  parameter int GOP_DLY = srfd_pkg::GOP_DELAY_CYC, // Gate-on to sample delay
  parameter int SOP_CYC = srfd_pkg::SOP_MASK_CYC,  // Source-open mask
  parameter int OVP_CYC = srfd_pkg::OVP_MASK_CYC   // Overvoltage mask, above 4096
) (
  input wire logic clk,                 // 250 MHz clock
  input wire logic nrst,                // Async reset, active low
  input wire logic supply_ok,           // Supply above lockout release level
  input wire logic ss_done,             // Soft-start at completion level
  input wire logic enable_comp_in,      // Enable input at or above enable level
  input wire logic general_comp,        // Enable pin above comparator reference
  input wire logic [1:0] gate_cmd,      // Rectifier gate requests, a and b
  input wire logic [1:0] drain_pulse,   // Drain pulse detect, a and b
  input wire logic [1:0] drain_neg,     // Drain below gate-open threshold
  input wire logic [1:0] drain_low,     // Drain below open threshold
  input wire logic [1:0] src_high,      // Source above open threshold
  input wire logic ovp_high,            // Overvoltage comparator
  input wire logic ovp_cancel,          // Below overvoltage cancel level
  output logic undervoltage_lockout,    // Lockout active
  output logic ss_charge,               // Soft-start charge current on
  output logic ss_discharge,            // Soft-start discharge on
  output logic reg_enable,              // Driver-supply regulator on
  output logic reg_discharge,           // Driver-supply discharge on
  output logic gate_drive_a,            // Gate drive a
  output logic gate_drive_b,            // Gate drive b
  output logic detect_active,           // Gate/drain open detection running
  output logic fail_sink_out,           // Constant current fail sink on
  output srfd_pkg::srfd_fault_s faults  // Sticky fault flags
);
  localparam int GW = $clog2(GOP_COUNT + 1);
  localparam int DW = $clog2(DOP_COUNT + 1);
  localparam logic [GW-1:0] GOP_LAST = GW'(GOP_COUNT);
  localparam logic [DW-1:0] DOP_LAST = DW'(DOP_COUNT);
  localparam int TW = $clog2(GOP_DLY + 2);
  localparam logic [TW-1:0] TAP = TW'(GOP_DLY);

  logic [8:0] sync_q;
  srfd_chan_s [1:0] ch;
  logic [1:0] pulse_s;
  logic ovp_s;
  logic [1:0] pulse_prev_q;
  logic [1:0] pulse_rise;
  srfd_state_e state_q, state_d;
  logic [2:0] start_cnt_q;
  logic reg_on_q;
  srfd_fault_s flt_q, flt_d;
  logic stop_all;
  logic [GW-1:0] gop_cnt_q;
  logic [DW-1:0] dop_cnt_q [2];
  logic [TW-1:0] gdly_q [2];
  logic [1:0] sample_now;
  logic [1:0] dop_hit;
  logic gop_any_sample, gop_any_ok;
  logic sop_done, ovp_done;
  logic [1:0] sop_done_ch;
  logic gate_a_q, gate_b_q;
  logic run_next;

  srfd_sync #(.W(9)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({ovp_high, src_high, drain_low, drain_neg, drain_pulse}),
    .q(sync_q)
  );

  assign pulse_s = sync_q[1:0];
  assign ovp_s = sync_q[8];
  assign pulse_rise = pulse_s & ~pulse_prev_q;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_ch
      assign ch[i].drain_neg = sync_q[2 + i];
      assign ch[i].drain_low = sync_q[4 + i];
      assign ch[i].src_high = sync_q[6 + i];
      assign ch[i].gate_on = i == 0 ? gate_a_q : gate_b_q;

      // Sample point a fixed delay after gate turn-on
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          gdly_q[i] <= '0;
        end else if (!ch[i].gate_on) begin
          gdly_q[i] <= '0;
        end else if (gdly_q[i] <= TAP) begin
          gdly_q[i] <= gdly_q[i] + 1'b1;
        end
      end
      assign sample_now[i] = ch[i].gate_on && (gdly_q[i] == TAP);  // [RQ5]

      // Drain i low while opposite drain pulses
      assign dop_hit[i] = detect_active && pulse_rise[1 - i];
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          dop_cnt_q[i] <= '0;
        end else if (!detect_active || !ch[i].drain_low) begin
          dop_cnt_q[i] <= '0;  // [RQ10]
        end else if (dop_hit[i] && dop_cnt_q[i] != DOP_LAST) begin
          dop_cnt_q[i] <= dop_cnt_q[i] + 1'b1;  // [RQ9]
        end
      end

      srfd_timer #(.CYC(SOP_CYC)) u_sop (
        .clk(clk),
        .nrst(nrst),
        .cond(ch[i].src_high),
        .done(sop_done_ch[i])
      );  // [RQ12]
    end
  endgenerate

  assign sop_done = |sop_done_ch;

  srfd_timer #(.CYC(OVP_CYC)) u_ovp (
    .clk(clk),
    .nrst(nrst),
    .cond(ovp_s),
    .done(ovp_done)
  );

  // Gate-open: consecutive open samples over both channels
  assign gop_any_sample = detect_active && |sample_now;
  assign gop_any_ok = |(sample_now & {~ch[1].drain_neg, ~ch[0].drain_neg});

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gop_cnt_q <= '0;
    end else if (!detect_active || gop_any_ok) begin
      gop_cnt_q <= '0;  // [RQ7]
    end else if (gop_any_sample && gop_cnt_q != GOP_LAST) begin
      gop_cnt_q <= gop_cnt_q + 1'b1;  // [RQ6]
    end
  end

  // Sticky faults; lockout clears them, overvoltage also on cancel
  always_comb begin
    flt_d = flt_q;
    if (gop_cnt_q == GOP_LAST) flt_d.gate_open = 1'b1;  // [RQ6] [RQ19]
    if (dop_cnt_q[0] == DOP_LAST || dop_cnt_q[1] == DOP_LAST) begin
      flt_d.drain_open = 1'b1;  // [RQ9]
    end
    if (sop_done) flt_d.src_open = 1'b1;  // [RQ13]
    if (ovp_done) begin
      flt_d.overvoltage_detect = 1'b1;  // [RQ14]
    end else if (ovp_cancel) begin
      flt_d.overvoltage_detect = 1'b0;  // [RQ14]
    end
    if (!supply_ok) flt_d = '0;  // [RQ16]
  end

  assign stop_all = flt_q.drain_open | flt_q.src_open | flt_q.overvoltage_detect;  // [RQ11] [RQ13] [RQ14]

  // Startup sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      SRFD_LOCKOUT: if (supply_ok) state_d = SRFD_CHARGE;  // [RQ1]
      SRFD_CHARGE: begin
        if (ss_done && enable_comp_in) state_d = SRFD_RUN;  // [RQ3]
        else if (ss_done) state_d = SRFD_DISCHARGE;  // [RQ4]
      end
      SRFD_DISCHARGE: if (enable_comp_in) state_d = SRFD_CHARGE;  // [RQ4]
      SRFD_RUN: state_d = SRFD_RUN;
      default: state_d = SRFD_LOCKOUT;
    endcase
    if (stop_all && state_q != SRFD_LOCKOUT) state_d = SRFD_DISCHARGE;  // [RQ11]
    if (!supply_ok) state_d = SRFD_LOCKOUT;  // [RQ1]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SRFD_LOCKOUT;
      flt_q <= '0;
      pulse_prev_q <= '0;
    end else begin
      state_q <= state_d;
      flt_q <= flt_d;
      pulse_prev_q <= pulse_s;
    end
  end

  // Regulator enable after four drain pulses since lockout release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_cnt_q <= '0;
      reg_on_q <= 1'b0;
    end else if (state_q == SRFD_LOCKOUT || stop_all) begin
      start_cnt_q <= '0;
      reg_on_q <= 1'b0;
    end else if (start_cnt_q == 3'(STARTUP_PULSES)) begin
      reg_on_q <= 1'b1;  // [RQ2]
    end else begin
      start_cnt_q <= start_cnt_q + 3'(pulse_rise[0]) + 3'(pulse_rise[1]) > 3'(STARTUP_PULSES)
        ? 3'(STARTUP_PULSES) : start_cnt_q + 3'(pulse_rise[0]) + 3'(pulse_rise[1]);
    end
  end

  // Gate drivers run only in the run state; gate-open keeps them going.
  // Next-state decode, so a stop fault drops both gates on the edge that latches it.
  assign run_next = (state_d == SRFD_RUN) && !(flt_d.drain_open | flt_d.src_open | flt_d.overvoltage_detect);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gate_a_q <= 1'b0;
      gate_b_q <= 1'b0;
    end else begin
      gate_a_q <= run_next && gate_cmd[0];  // [RQ3] [RQ8] [RQ11]
      gate_b_q <= run_next && gate_cmd[1];
    end
  end

  assign detect_active = (state_q == SRFD_RUN) && !stop_all;  // [RQ3]
  assign undervoltage_lockout = state_q == SRFD_LOCKOUT;
  assign ss_charge = state_q == SRFD_CHARGE;  // [RQ1]
  assign ss_discharge = state_q == SRFD_DISCHARGE || stop_all;  // [RQ4] [RQ11]
  assign reg_enable = reg_on_q;
  assign reg_discharge = stop_all;  // [RQ11]
  assign gate_drive_a = gate_a_q;
  assign gate_drive_b = gate_b_q;
  assign faults = flt_q;
  assign fail_sink_out = (|flt_q) | general_comp;  // [RQ15] [RQ17] [RQ19]
endmodule

// ### testbench/srfd_checker.sv
`timescale 1ns/1ns
module srfd_checker
  import srfd_pkg::*;
#(
  parameter int SOP_CYC = 5
) (
  input wire logic clk, // Clock
  input wire logic nrst, // Reset
  input wire logic supply_ok, // In
  input wire logic general_comp, // In
  input wire logic [1:0] gate_cmd, // In
  input wire logic [1:0] src_high, // In
  input wire logic ovp_high, // In
  input wire logic undervoltage_lockout, // Out
  input wire logic ss_charge, // Out
  input wire logic ss_discharge, // Out
  input wire logic reg_discharge, // Out
  input wire logic gate_drive_a, // Out
  input wire logic gate_drive_b, // Out
  input wire logic detect_active, // Out
  input wire logic fail_sink_out, // Out
  input wire srfd_pkg::srfd_fault_s faults // Out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [7:0] src_cnt_q;
  logic stop;
  assign stop = faults.drain_open | faults.src_open | faults.overvoltage_detect;
  // Consecutive cycles of raw source-high on channel a
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) src_cnt_q <= 8'h00;
    else if (!(supply_ok && src_high[0])) src_cnt_q <= 8'h00;
    else if (src_cnt_q != 8'hFF) src_cnt_q <= src_cnt_q + 8'h01;
  end
  sequence s_release;
    $fell(undervoltage_lockout);
  endsequence
  a_fail_or: assert property (fail_sink_out == ((|faults) | general_comp))
    else $error("fail sink not the or of faults");
  a_start_charge: assert property (s_release |-> ss_charge)
    else $error("no charge after lockout release");
  a_lock_entry: assert property (!supply_ok |=> undervoltage_lockout)
    else $error("lockout not entered");
  a_lock_clear: assert property (!supply_ok [*2] |-> faults == '0)
    else $error("faults kept in lockout");
  a_gate_follow: assert property (detect_active [*2] |->
    gate_drive_a == $past(gate_cmd[0]) && gate_drive_b == $past(gate_cmd[1]))
    else $error("gate drive not following request");
  a_idle_gates: assert property (!detect_active [*2] |-> !gate_drive_a && !gate_drive_b)
    else $error("gate driven while idle");
  a_gop_keeps: assert property ($rose(faults.gate_open) && !stop |-> detect_active)
    else $error("rectification stopped on gate open");
  a_stop_all: assert property (stop |->
    !gate_drive_a && !gate_drive_b && ss_discharge && reg_discharge)
    else $error("stop fault left drivers running");
  a_src_mask: assert property (src_cnt_q >= SOP_CYC + 5 |-> faults.src_open)
    else $error("source open not confirmed");
  a_ovp_cause: assert property ($rose(faults.overvoltage_detect) |-> $past(ovp_high, 3))
    else $error("overvoltage flag without cause");
endmodule
bind srfd_top srfd_checker #(.SOP_CYC(SOP_CYC)) srfd_checker_i (.*);

// ### testbench/srfd_fet_model.sv
`timescale 1ns/1ns
module srfd_fet_model (
  input wire logic clk, // Clock
  input wire logic run, // Primary side switching
  input wire logic [1:0] gopen, // Gate pin open per channel
  input wire logic [1:0] dopen, // Drain pin open per channel
  output logic [1:0] gate_cmd, // Gate requests
  output logic [1:0] drain_pulse, // Conduction pulses
  output logic [1:0] drain_neg, // Drain under gate-open level
  output logic [1:0] drain_low // Drain under open level
);
  logic [3:0] ph_q = 4'h0;
  logic [1:0] cond;
  always @(posedge clk) ph_q <= run ? ph_q + 4'h1 : 4'h0;
  // Channels conduct alternately, eight cycles each
  assign cond = run ? {ph_q[3], !ph_q[3]} : 2'b00;
  assign gate_cmd = cond;
  assign drain_pulse = cond & ~dopen;
  assign drain_neg = drain_pulse & gopen;
  assign drain_low = drain_pulse | dopen;
endmodule

// ### testbench/srfd_top_test.sv
`timescale 1ns/1ns
module srfd_top_test;
  import srfd_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic supply_ok = 1'b0, ss_done = 1'b0, enable_comp_in = 1'b0, general_comp = 1'b0;
  logic ovp_high = 1'b0, ovp_cancel = 1'b0, run = 1'b0;
  logic [1:0] src_high = 2'b00, gopen = 2'b00, dopen = 2'b00;
  logic [1:0] gate_cmd, drain_pulse, drain_neg, drain_low;
  logic undervoltage_lockout, ss_charge, ss_discharge, reg_enable, reg_discharge;
  logic gate_drive_a, gate_drive_b, detect_active, fail_sink_out;
  srfd_fault_s faults;
  int error_cnt = 0;
  int n_checks = 0;
  always #2 clk = ~clk;
  srfd_fet_model srfd_fet_model_i (.clk(clk), .run(run), .gopen(gopen), .dopen(dopen),
    .gate_cmd(gate_cmd), .drain_pulse(drain_pulse), .drain_neg(drain_neg),
    .drain_low(drain_low));
  srfd_top #(.GOP_COUNT(8), .DOP_COUNT(4), .GOP_DLY(3), .SOP_CYC(5), .OVP_CYC(10))
    srfd_top_i (.*);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic lockout();
    supply_ok = 1'b0;
    run = 1'b0;
    ss_done = 1'b0;
    enable_comp_in = 1'b0;
    {gopen, dopen, src_high, ovp_high, ovp_cancel} = 8'h00;
    cyc(3);
    chk({undervoltage_lockout, faults, fail_sink_out}, 8'h20);
  endtask
  task automatic bring_up();
    supply_ok = 1'b1;
    run = 1'b1;
    enable_comp_in = 1'b1;
    cyc(2);
    ss_done = 1'b1;
    cyc(40);
  endtask
  initial begin
    cyc(2);
    chk({undervoltage_lockout, fail_sink_out, ss_charge, reg_enable}, 8'h08);
    nrst = 1'b1;
    cyc(1);
    supply_ok = 1'b1;
    cyc(2);
    chk({undervoltage_lockout, ss_charge, ss_discharge, detect_active}, 8'h04);
    run = 1'b1;
    cyc(12);
    chk(reg_enable, 8'h00);
    cyc(30);
    chk(reg_enable, 8'h01);
    general_comp = 1'b1;
    cyc(1);
    chk(fail_sink_out, 8'h01);
    general_comp = 1'b0;
    cyc(1);
    chk(fail_sink_out, 8'h00);
    ss_done = 1'b1;
    cyc(2);
    chk({ss_charge, ss_discharge, detect_active}, 8'h02);
    ss_done = 1'b0;
    enable_comp_in = 1'b1;
    cyc(2);
    chk({ss_charge, ss_discharge, detect_active}, 8'h04);
    ss_done = 1'b1;
    cyc(2);
    chk({ss_charge, ss_discharge, detect_active}, 8'h01);
    gopen = 2'b01;
    cyc(200);
    chk(faults, 8'h00);
    gopen = 2'b11;
    cyc(150);
    chk({faults, fail_sink_out, detect_active}, 8'h23);
    lockout();
    bring_up();
    dopen = 2'b01;
    cyc(40);
    dopen = 2'b00;
    cyc(16);
    dopen = 2'b01;
    cyc(40);
    chk(faults, 8'h00);
    cyc(60);
    chk({faults, gate_drive_a, gate_drive_b, ss_discharge, reg_discharge}, 8'h43);
    lockout();
    supply_ok = 1'b1;
    cyc(2);
    src_high = 2'b10;
    cyc(4);
    src_high = 2'b00;
    cyc(4);
    chk(faults, 8'h00);
    src_high = 2'b01;
    cyc(14);
    chk({faults, ss_discharge, reg_discharge, fail_sink_out}, 8'h17);
    lockout();
    bring_up();
    ovp_high = 1'b1;
    cyc(6);
    chk(faults, 8'h00);
    cyc(14);
    chk({faults, fail_sink_out, ss_discharge, reg_discharge, detect_active}, 8'h1E);
    ovp_high = 1'b0;
    ovp_cancel = 1'b1;
    cyc(5);
    chk(faults, 8'h00);
    report_and_stop();
  end
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
endmodule
